// [common/lcc_regs.vh]
// register map, field positions and codes of the logic cell control stage
`ifndef LCC_REGS_VH
`define LCC_REGS_VH

`define LCC_AW 6
`define LCC_ADDR_CON 6'h00
`define LCC_ADDR_POL 6'h04
`define LCC_ADDR_SEL0 6'h08
`define LCC_ADDR_SEL1 6'h0C
`define LCC_ADDR_SEL2 6'h10
`define LCC_ADDR_SEL3 6'h14
`define LCC_ADDR_GLS0 6'h18
`define LCC_ADDR_GLS1 6'h1C
`define LCC_ADDR_GLS2 6'h20
`define LCC_ADDR_GLS3 6'h24
`define LCC_ADDR_FLAG 6'h28
`define LCC_ADDR_MIRROR 6'h2C

`define LCC_CON_EN 7
`define LCC_CON_OUT 5
`define LCC_CON_RISE 4
`define LCC_CON_FALL 3
`define LCC_CON_FN_HI 2
`define LCC_CON_FN_LO 0
`define LCC_CON_WMASK 8'h9F
`define LCC_CON_RST 8'h00

`define LCC_POL_OUT 7
`define LCC_POL_OUT_RST 1'b0
`define LCC_SEL_HI 4
`define LCC_FLAG_BIT 0

`define LCC_FN_ANDOR 3'h0
`define LCC_FN_ORXOR 3'h1
`define LCC_FN_AND4 3'h2
`define LCC_FN_SRL 3'h3
`define LCC_FN_DFFSR 3'h4
`define LCC_FN_DFF2R 3'h5
`define LCC_FN_JKR 3'h6
`define LCC_FN_LATSR 3'h7

`define LCC_SRC_FAST_OSC 5'h1F
`define LCC_CELL_IDX 2'h0
`define LCC_RESP_OKAY 2'h0
`define LCC_RESP_SLVERR 2'h2

`endif

// [hdl/lcc_top.v]
// logic cell control, gating, function, output polarity and edge flag stage
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`include "lcc_regs.vh"

// Behaviour
// - mirror read captures all four cell outputs in one clock.
// - any reset clears control; selectors, gate selects, gate polarities keep values.
// - cell keeps running regardless of sleep while sources stay active.
// - enabled cell selecting fast oscillator requests oscillator kept on.
// - enable bit 7 set combines inputs; clear forces output zero.
// - control bit 5 reads output after output inversion.
// - rise enable bit 4 lets a rising output edge set the flag.
// - fall enable bit 3 lets a falling output edge set the flag.
// - codes 100 DFF S/R, 101 2-in DFF R, 110 JK R, 111 latch S/R.
// - polarity bit 7 inverts function output.
// - polarity bits 3..0 invert gates 4..1 before the function.
// - selectors hold five bits; bits 7..5 read zero.
// - control bit 6 and polarity bits 6..4 read zero, ignore writes.
// - gate ANDs chosen true/negated inputs; empty gate is polarity only.
// - gate select bit 7 data4 true down to bit 0 data1 negated.
// - software clears flag; a coincident edge leaves it set.
// - changing output polarity with edges enabled flags the transition.
module lcc_top (
  input wire aclk,
  input wire aresetn,
  input wire [5:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] cell_in,
  input wire [3:0] peer_cell_out,
  output wire cell_out,
  output wire cell_irq_flag,
  output wire fast_osc_keep_on
);

  function lcc_mapped;
    input [5:0] a;
    begin
      lcc_mapped = ({a[5:2], 2'b00} <= `LCC_ADDR_MIRROR);
    end
  endfunction

  // gate: AND of the enabled true/negated terms; no term enabled gives zero
  function gate_eval;
    input [7:0] en;
    input [3:0] d;
    reg [7:0] t;
    begin
      t = {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
      gate_eval = (en != 8'h00) & (&(t | ~en));
    end
  endfunction

  reg [7:0] con_r;
  reg out_inv_r;
  reg [3:0] gate_inv_r;
  reg [4:0] sel_r [0:3];
  reg [7:0] gls_r [0:3];
  reg flag_r;
  reg q_r;
  reg q_nxt;
  reg clk_prev_r;
  reg lc_out_r;
  reg keep_on_r;

  reg aw_have_r;
  reg w_have_r;
  reg [5:0] awaddr_r;
  reg [7:0] wdata_r;
  reg wlane_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [7:0] rdata_r;
  reg [1:0] rresp_r;
  reg [7:0] rd_nxt;

  wire do_wr = aw_have_r & w_have_r & ~bvalid_r;
  wire wr_ok = do_wr & wlane_r & lcc_mapped(awaddr_r);
  wire [5:0] wa = {awaddr_r[5:2], 2'b00};
  wire rd_go = s_axi_arvalid & ~rvalid_r;
  wire [5:0] ra = {s_axi_araddr[5:2], 2'b00};

  assign s_axi_awready = ~aw_have_r & ~bvalid_r;
  assign s_axi_wready = ~w_have_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = {24'h000000, rdata_r};

  // data selection and gating
  wire [3:0] data;
  wire [3:0] g;
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : gsel
      assign data[k] = cell_in[sel_r[k]];
      assign g[k] = gate_eval(gls_r[k], data) ^ gate_inv_r[k];
    end
  endgenerate

  wire en = con_r[`LCC_CON_EN];
  wire [2:0] fn = con_r[`LCC_CON_FN_HI:`LCC_CON_FN_LO];
  wire clk_rise = g[0] & ~clk_prev_r;
  reg comb_out;
  reg fn_out;

  // sequential functions evaluated at the system clock; g[0] clocks the DFF and JK functions
  always @* begin
    q_nxt = q_r;
    comb_out = 1'b0;
    case (fn)
      `LCC_FN_ANDOR: comb_out = (g[0] & g[1]) | (g[2] & g[3]);
      `LCC_FN_ORXOR: comb_out = (g[0] | g[1]) ^ (g[2] | g[3]);
      `LCC_FN_AND4: comb_out = &g;
      `LCC_FN_SRL: begin
        if (g[0] | g[1])
          q_nxt = 1'b1;
        else if (g[2] | g[3])
          q_nxt = 1'b0;
      end
      `LCC_FN_DFFSR: begin
        if (g[2])
          q_nxt = 1'b0;
        else if (g[3])
          q_nxt = 1'b1;
        else if (clk_rise)
          q_nxt = g[1];
      end
      `LCC_FN_DFF2R: begin
        if (g[2])
          q_nxt = 1'b0;
        else if (clk_rise)
          q_nxt = g[1] & g[3];
      end
      `LCC_FN_JKR: begin
        if (g[2])
          q_nxt = 1'b0;
        else if (clk_rise) begin
          case ({g[1], g[3]})
            2'b10: q_nxt = 1'b1;
            2'b01: q_nxt = 1'b0;
            2'b11: q_nxt = ~q_r;
            default: q_nxt = q_r;
          endcase
        end
      end
      `LCC_FN_LATSR: begin
        if (g[2])
          q_nxt = 1'b0;
        else if (g[3])
          q_nxt = 1'b1;
        else if (g[0])
          q_nxt = g[1];
      end
      default: comb_out = 1'b0;
    endcase
    if (!en)
      q_nxt = 1'b0;
    fn_out = fn[2] | (fn == `LCC_FN_SRL) ? q_nxt : comb_out;
  end

  // disabled cell drives zero after the inverter as well
  wire out_nxt = en & (fn_out ^ out_inv_r);
  wire rise = out_nxt & ~lc_out_r;
  wire fall = ~out_nxt & lc_out_r;
  wire edge_hit = (rise & con_r[`LCC_CON_RISE]) | (fall & con_r[`LCC_CON_FALL]);
  wire flag_clr = wr_ok & (wa == `LCC_ADDR_FLAG) & wdata_r[`LCC_FLAG_BIT];

  reg src_fast;
  integer i;
  integer n;
  always @* begin
    src_fast = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (sel_r[i] == `LCC_SRC_FAST_OSC)
        src_fast = 1'b1;
    end
  end

  // no clock gating or sleep input: the cell runs whenever aclk runs
  always @(posedge aclk) begin
    if (!aresetn) begin
      con_r <= `LCC_CON_RST;
      out_inv_r <= `LCC_POL_OUT_RST;
      flag_r <= 1'b0;
      q_r <= 1'b0;
      clk_prev_r <= 1'b0;
      lc_out_r <= 1'b0;
      keep_on_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      clk_prev_r <= g[0];
      lc_out_r <= out_nxt;
      keep_on_r <= en & src_fast;
      if (edge_hit)
        flag_r <= 1'b1;
      else if (flag_clr)
        flag_r <= 1'b0;
      if (wr_ok && wa == `LCC_ADDR_CON)
        con_r <= wdata_r & `LCC_CON_WMASK;
      if (wr_ok && wa == `LCC_ADDR_POL)
        out_inv_r <= wdata_r[`LCC_POL_OUT];
    end
  end

  // configuration kept across every reset, unknown at power-up
  always @(posedge aclk) begin
    if (wr_ok && wa == `LCC_ADDR_POL)
      gate_inv_r <= wdata_r[3:0];
    for (n = 0; n < 4; n = n + 1) begin
      if (wr_ok && wa == `LCC_ADDR_SEL0 + 6'h04 * n[5:0])
        sel_r[n] <= wdata_r[`LCC_SEL_HI:0];
      if (wr_ok && wa == `LCC_ADDR_GLS0 + 6'h04 * n[5:0])
        gls_r[n] <= wdata_r;
    end
  end

  // write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 6'h00;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `LCC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= lcc_mapped(awaddr_r) ? `LCC_RESP_OKAY : `LCC_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // own bit replaced so the mirror never reads a stale copy of this cell
  wire [3:0] mirror = (peer_cell_out & ~(4'h1 << `LCC_CELL_IDX)) |
                      ({3'h0, lc_out_r} << `LCC_CELL_IDX);

  always @* begin
    rd_nxt = 8'h00;
    case (ra)
      `LCC_ADDR_CON: rd_nxt = (con_r & `LCC_CON_WMASK) |
                              ({7'h00, lc_out_r} << `LCC_CON_OUT);
      `LCC_ADDR_POL: rd_nxt = {out_inv_r, 3'h0, gate_inv_r};
      `LCC_ADDR_SEL0: rd_nxt = {3'h0, sel_r[0]};
      `LCC_ADDR_SEL1: rd_nxt = {3'h0, sel_r[1]};
      `LCC_ADDR_SEL2: rd_nxt = {3'h0, sel_r[2]};
      `LCC_ADDR_SEL3: rd_nxt = {3'h0, sel_r[3]};
      `LCC_ADDR_GLS0: rd_nxt = gls_r[0];
      `LCC_ADDR_GLS1: rd_nxt = gls_r[1];
      `LCC_ADDR_GLS2: rd_nxt = gls_r[2];
      `LCC_ADDR_GLS3: rd_nxt = gls_r[3];
      `LCC_ADDR_FLAG: rd_nxt = {7'h00, flag_r};
      `LCC_ADDR_MIRROR: rd_nxt = {4'h0, mirror};
      default: rd_nxt = 8'h00;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= `LCC_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_nxt;
      rresp_r <= lcc_mapped(s_axi_araddr) ? `LCC_RESP_OKAY : `LCC_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign cell_out = lc_out_r;
  assign cell_irq_flag = flag_r;
  assign fast_osc_keep_on = keep_on_r;

endmodule

// [verif/lcc_top_asserts.sv]
// assertion checker for the logic cell control top
module lcc_top_asserts (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire cell_out,
  input wire cell_irq_flag,
  input wire fast_osc_keep_on
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_rst_clear: assert property (disable iff (1'b0) !aresetn |=>
    !cell_out && !cell_irq_flag && !fast_osc_keep_on && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state not cleared by reset");
  chk_flag_clear: assert property ($fell(cell_irq_flag) |-> $rose(s_axi_bvalid))
    else $error("flag dropped without a write");
  chk_flag_cause: assert property ($rose(cell_irq_flag) |->
    $changed(cell_out) || $past(cell_out) != $past(cell_out, 2))
    else $error("flag rose without an output edge");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  chk_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  chk_wr_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_rdata_hi: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  cover property ($rose(cell_irq_flag));
  cover property ($rose(fast_osc_keep_on));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind lcc_top lcc_top_asserts chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .cell_out(cell_out),
  .cell_irq_flag(cell_irq_flag),
  .fast_osc_keep_on(fast_osc_keep_on)
);

// [verif/lcc_src_model.sv]
// far side: peripheral sources and peer cell outputs, moving on clock edges
module lcc_src_model (
  input wire aclk,
  input wire [31:0] next_in,
  input wire [3:0] next_peer,
  output logic [31:0] cell_in = 32'h0,
  output logic [3:0] peer_cell_out = 4'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge aclk) begin
    cell_in <= next_in;
    peer_cell_out <= next_peer;
  end
endmodule

// [verif/test_logic_cell_control_output.sv]
// self-checking bench for the logic cell control stage
`include "lcc_regs.vh"
module test_logic_cell_control_output;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0;
  logic aresetn = 0;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, next_in = 0, cell_in, v;
  logic [3:0] s_axi_wstrb = 4'h1, next_peer = 0, peer_cell_out;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire cell_out, cell_irq_flag, fast_osc_keep_on;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [33:0] exp_q[$];
  logic [1:0] exp_b[$];
  logic [4:0] k;
  integer bad_count = 0, total_checks = 0, cyc = 0, seed = 39478, i, j;
  lcc_src_model src (.aclk(aclk), .next_in(next_in), .next_peer(next_peer),
    .cell_in(cell_in), .peer_cell_out(peer_cell_out));
  lcc_top uut (.*);
  initial forever #5 aclk = ~aclk;
  task chk(input string n, input [33:0] e, input [33:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  // results come back in request order, one read at a time
  always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) chk("rdata", exp_q.pop_front(),
    {s_axi_rresp, s_axi_rdata});
  always @(posedge aclk) if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, exp_b.pop_front()},
    {32'h0, s_axi_bresp});
  task wr(input [5:0] a, input [7:0] d, input [1:0] r = `LCC_RESP_OKAY);
    exp_b.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task rd(input [5:0] a, input [7:0] d, input [1:0] r = `LCC_RESP_OKAY);
    exp_q.push_back({r, 24'h000000, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  // the cell path lags register writes and source changes by a cycle or two
  task settle;
    repeat (3) @(posedge aclk);
  endtask
  // empty gates follow their polarity bits; output seen through control bit 5
  task fstep(input [7:0] c, input [3:0] p, input o);
    wr(`LCC_ADDR_POL, {4'h0, p});
    rd(`LCC_ADDR_CON, c | {2'h0, o, 5'h00});
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(`LCC_ADDR_CON, 8'h00);
    rd(6'h30, 8'h00, `LCC_RESP_SLVERR);
    wr(6'h34, 8'hFF, `LCC_RESP_SLVERR);
    for (i = 0; i < 4; i++) begin
      wr(`LCC_ADDR_SEL0 + 6'(4 * i), 8'hE0 | 8'(i));
      rd(`LCC_ADDR_SEL0 + 6'(4 * i), 8'(i));
      wr(`LCC_ADDR_GLS0 + 6'(4 * i), 8'h00);
    end
    wr(`LCC_ADDR_POL, 8'hFF);
    rd(`LCC_ADDR_POL, 8'h8F);
    wr(`LCC_ADDR_POL, 8'h0F);
    $display("test registers done");
    // empty gates inverted: all four gates at one
    for (i = 0; i < 3; i++) begin
      wr(`LCC_ADDR_CON, 8'hC0 | 8'(i));
      settle;
      rd(`LCC_ADDR_CON, 8'h80 | 8'(i) | (i == 1 ? 8'h00 : 8'h20));
    end
    wr(`LCC_ADDR_POL, 8'h8F);
    settle;
    rd(`LCC_ADDR_CON, 8'h82);
    wr(`LCC_ADDR_POL, 8'h0E);
    settle;
    rd(`LCC_ADDR_CON, 8'h82);
    wr(`LCC_ADDR_POL, 8'h0F);
    wr(`LCC_ADDR_CON, 8'h02);
    settle;
    rd(`LCC_ADDR_CON, 8'h02);
    rd(`LCC_ADDR_FLAG, 8'h00);
    $display("test functions done");
    wr(`LCC_ADDR_CON, 8'h9A);
    settle;
    rd(`LCC_ADDR_FLAG, 8'h01);
    wr(`LCC_ADDR_FLAG, 8'h01);
    rd(`LCC_ADDR_FLAG, 8'h00);
    wr(`LCC_ADDR_POL, 8'h8F);
    settle;
    rd(`LCC_ADDR_FLAG, 8'h01);
    wr(`LCC_ADDR_FLAG, 8'h01);
    wr(`LCC_ADDR_CON, 8'h92);
    wr(`LCC_ADDR_POL, 8'h0F);
    settle;
    rd(`LCC_ADDR_FLAG, 8'h01);
    wr(`LCC_ADDR_FLAG, 8'h01);
    wr(`LCC_ADDR_POL, 8'h8F);
    settle;
    rd(`LCC_ADDR_FLAG, 8'h00);
    $display("test flag done");
    v = $random(seed);
    next_peer <= v[3:0];
    settle;
    rd(`LCC_ADDR_MIRROR, {4'h0, v[3:1], 1'b0});
    wr(`LCC_ADDR_SEL1, 8'h1F);
    settle;
    chk("keep_on", 34'h1, {33'h0, fast_osc_keep_on});
    wr(`LCC_ADDR_CON, 8'h12);
    settle;
    chk("keep_on", 34'h0, {33'h0, fast_osc_keep_on});
    wr(`LCC_ADDR_POL, 8'h00);
    wr(`LCC_ADDR_CON, 8'h83);
    fstep(8'h83, 4'h1, 1'b1);
    fstep(8'h83, 4'h0, 1'b1);
    fstep(8'h83, 4'h4, 1'b0);
    fstep(8'h83, 4'h2, 1'b1);
    fstep(8'h83, 4'h8, 1'b0);
    fstep(8'h83, 4'h5, 1'b1);
    wr(`LCC_ADDR_CON, 8'h84);
    fstep(8'h84, 4'h2, 1'b0);
    fstep(8'h84, 4'h3, 1'b1);
    fstep(8'h84, 4'h0, 1'b1);
    fstep(8'h84, 4'h4, 1'b0);
    fstep(8'h84, 4'h8, 1'b1);
    wr(`LCC_ADDR_CON, 8'h85);
    fstep(8'h85, 4'h4, 1'b0);
    fstep(8'h85, 4'h2, 1'b0);
    fstep(8'h85, 4'hB, 1'b1);
    fstep(8'h85, 4'h2, 1'b1);
    fstep(8'h85, 4'h3, 1'b0);
    wr(`LCC_ADDR_CON, 8'h86);
    fstep(8'h86, 4'hA, 1'b0);
    fstep(8'h86, 4'hB, 1'b1);
    fstep(8'h86, 4'hA, 1'b1);
    fstep(8'h86, 4'hB, 1'b0);
    fstep(8'h86, 4'hA, 1'b0);
    fstep(8'h86, 4'h3, 1'b1);
    fstep(8'h86, 4'h2, 1'b1);
    fstep(8'h86, 4'h9, 1'b0);
    wr(`LCC_ADDR_CON, 8'h87);
    fstep(8'h87, 4'h3, 1'b1);
    fstep(8'h87, 4'h1, 1'b0);
    fstep(8'h87, 4'h2, 1'b0);
    fstep(8'h87, 4'h3, 1'b1);
    fstep(8'h87, 4'h2, 1'b1);
    fstep(8'h87, 4'h0, 1'b1);
    fstep(8'h87, 4'h4, 1'b0);
    $display("test sequential done");
    wr(`LCC_ADDR_POL, 8'h0E);
    wr(`LCC_ADDR_CON, 8'h82);
    v = $random(seed);
    k = v[4:0];
    wr(`LCC_ADDR_SEL0, {3'h0, k});
    for (j = 0; j < 2; j++) begin
      wr(`LCC_ADDR_GLS0, 8'h02 >> j);
      for (i = 0; i < 6; i++) begin
        next_in <= $random(seed);
        settle;
        chk("cell_out", {33'h0, next_in[k] ^ j[0]}, {33'h0, cell_out});
      end
    end
    $display("test gating done");
    // output edge lands on the very edge at which the flag clear is written
    wr(`LCC_ADDR_CON, 8'h9A);
    fork
      wr(`LCC_ADDR_FLAG, 8'h01);
      begin
        @(posedge aclk);
        next_in <= ~next_in;
      end
    join
    settle;
    rd(`LCC_ADDR_FLAG, 8'h01);
    chk("irq_flag", 34'h1, {33'h0, cell_irq_flag});
    wr(`LCC_ADDR_FLAG, 8'h01);
    rd(`LCC_ADDR_FLAG, 8'h00);
    $display("test coincident clear done");
    aresetn <= 0;
    @(posedge aclk);
    aresetn <= 1;
    rd(`LCC_ADDR_CON, 8'h00);
    rd(`LCC_ADDR_POL, 8'h0E);
    rd(`LCC_ADDR_SEL0, {3'h0, k});
    $display("test reset done");
    tally_and_finish;
  end
endmodule
